// >>> ata_cmd_core.sv
// Purpose: Executes decoded sub-commands and the power-state query.
// Assumes: Host writes the task file and pulses i_cmd_wr with the command.
// Notes: Results are posted together with a one-cycle interrupt pulse.
`timescale 1ns/1ps
module ata_cmd_core
  import ata_cmd_pkg::*;
(
  input wire logic i_sys_clk, // 250 MHz clock.
  input wire logic i_rst, // Asynchronous reset, active high.
  input wire logic i_cmd_wr, // Command byte written, one-cycle pulse.
  input wire logic [7:0] i_cmd, // Command code.
  input wire logic [7:0] i_feature, // Feature byte.
  input wire logic [7:0] i_sector_count, // Sector count byte.
  input wire logic [7:0] i_device_head, // Device/head byte.
  input wire logic [1:0] i_power_state, // Current power state.
  input wire logic i_ext_done, // Other-command body finished, pulse.
  input wire logic i_ext_fault, // Other-command body failed, level.
  output logic [7:0] o_device_condition_flags, // Status register.
  output logic [7:0] o_command_error_flags, // Error register.
  output logic [7:0] o_sector_count, // Sector count returned.
  output logic o_intrq, // Completion interrupt pulse.
  output logic o_lba_mode, // Addressing mode of last command.
  output logic o_max_option, // Option bit of max-address setting.
  output logic o_set_max_go, // Max-address setting pulse.
  output logic o_read_values, // Return attribute values pulse.
  output logic o_read_thresh, // Return attribute thresholds pulse.
  output logic o_save_now, // Save attributes pulse.
  output logic o_autosave_en, // Attribute autosave enable.
  output logic o_offline_start, // Start off-line collection pulse.
  output logic o_apm_en, // Advanced power management enable.
  output logic o_puis_en, // Power-up-in-standby enable.
  output logic o_spin_up, // Spin-up request pulse.
  output logic o_lookahead_en, // Read look-ahead enable.
  output logic o_revert_en, // Revert to defaults enable.
  output logic o_ext_start // Other command handed on, pulse.
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  op_t dec_op;
  op_t op_reg;
  op_t op_next;
  cmd_state_t state_reg;
  cmd_state_t state_next;
  logic [5:0] cnt_reg;
  logic [5:0] cnt_next;
  logic [7:0] fcnt_reg;
  logic [7:0] stat_reg;
  logic [7:0] stat_next;
  logic [7:0] err_reg;
  logic [7:0] err_next;
  logic [7:0] sc_reg;
  logic [7:0] sc_next;
  logic intrq_reg;
  logic lba_reg;
  logic opt_reg;
  logic setmax_reg;
  logic rv_reg;
  logic rt_reg;
  logic sv_reg;
  logic as_reg;
  logic as_next;
  logic off_reg;
  logic apm_reg;
  logic apm_next;
  logic puis_reg;
  logic puis_next;
  logic spin_reg;
  logic rla_reg;
  logic rla_next;
  logic rev_reg;
  logic rev_next;
  logic ext_reg;

  ata_sub_decode u_dec (
    .i_cmd(i_cmd),
    .i_feature(i_feature),
    .o_op(dec_op)
  );

  // Bit 4 of the device/head byte is never looked at.
  wire accept = i_cmd_wr && (state_reg == S_IDLE);
  wire exec_done = (state_reg == S_EXEC) &&
    ((op_reg == OP_PASS) ? i_ext_done : (cnt_reg == 6'h00));
  wire stopped = (i_power_state == PWR_STANDBY) ||
    (i_power_state == PWR_SLEEP);
  wire is_abort = (op_reg == OP_ABORT) ||
    ((op_reg == OP_PASS) && i_ext_fault);
  wire go = (state_reg == S_EXEC) && (cnt_reg == EXEC_CYCLES);

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    op_next = op_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      S_IDLE: begin
        if (accept) begin
          state_next = S_EXEC;
          op_next = dec_op;
          cnt_next = EXEC_CYCLES;
        end
      end
      S_EXEC: begin
        if (cnt_reg != 6'h00) begin
          cnt_next = cnt_reg - 6'h01;
        end
        if (exec_done) begin
          state_next = S_POST;
        end
      end
      S_POST: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Result and feature state
  // ---------------------------------------------------------------
  always_comb begin
    stat_next = stat_reg;
    err_next = err_reg;
    sc_next = sc_reg;
    if (accept) begin
      stat_next[ST_BUSY] = 1'b1;
      stat_next[ST_DATA_REQ] = 1'b0;
    end
    if (exec_done) begin
      // Final flags appear only here, at completion.
      stat_next = 8'h00;
      stat_next[ST_READY] = 1'b1;
      stat_next[ST_SEEK_DONE] = 1'b1;
      stat_next[ST_ERR] = is_abort;
      err_next = 8'h00;
      err_next[ER_ABORT] = is_abort;
      if (op_reg == OP_POWER_QUERY) begin
        // The power state is only sampled, never changed.
        sc_next = stopped ? PWR_CODE_STOPPED :
          PWR_CODE_ACTIVE;
      end
    end
  end

  always_comb begin
    as_next = as_reg;
    apm_next = apm_reg;
    puis_next = puis_reg;
    rla_next = rla_reg;
    rev_next = rev_reg;
    if (go) begin
      case (op_reg)
        OP_AUTOSAVE: as_next = (fcnt_reg == FT_AUTOSAVE_ON);
        OP_APM_ON: apm_next = 1'b1;
        OP_APM_OFF: apm_next = 1'b0;
        OP_PUIS_ON: puis_next = 1'b1;
        OP_PUIS_OFF: puis_next = 1'b0;
        OP_RLA_OFF: rla_next = 1'b0;
        OP_RLA_ON: rla_next = 1'b1;
        OP_REVERT_OFF: rev_next = 1'b0;
        OP_REVERT_ON: rev_next = 1'b1;
        default: as_next = as_reg;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
      op_reg <= OP_NONE;
      cnt_reg <= 6'h00;
    end else begin
      state_reg <= state_next;
      op_reg <= op_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      stat_reg <= STATUS_RESET;
      err_reg <= ERROR_RESET;
      sc_reg <= 8'h00;
      intrq_reg <= 1'b0;
    end else begin
      stat_reg <= stat_next;
      err_reg <= err_next;
      sc_reg <= sc_next;
      intrq_reg <= exec_done;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      lba_reg <= 1'b0;
      opt_reg <= 1'b0;
      fcnt_reg <= 8'h00;
    end else if (accept) begin
      lba_reg <= i_device_head[LBA_BIT];
      opt_reg <= i_sector_count[OPTION_BIT];
      fcnt_reg <= i_sector_count;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      as_reg <= 1'b0;
      apm_reg <= 1'b0;
      puis_reg <= 1'b0;
      rla_reg <= 1'b1;
      rev_reg <= 1'b1;
    end else begin
      as_reg <= as_next;
      apm_reg <= apm_next;
      puis_reg <= puis_next;
      rla_reg <= rla_next;
      rev_reg <= rev_next;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      setmax_reg <= 1'b0;
      rv_reg <= 1'b0;
      rt_reg <= 1'b0;
      sv_reg <= 1'b0;
      off_reg <= 1'b0;
      spin_reg <= 1'b0;
      ext_reg <= 1'b0;
    end else begin
      setmax_reg <= go && (op_reg == OP_SET_MAX);
      rv_reg <= go && (op_reg == OP_READ_VALUES);
      rt_reg <= go && (op_reg == OP_READ_THRESH);
      sv_reg <= go && (op_reg == OP_SAVE_NOW);
      off_reg <= go && (op_reg == OP_OFFLINE);
      spin_reg <= go && (op_reg == OP_SPIN_UP) && puis_reg;
      ext_reg <= accept && (dec_op == OP_PASS);
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_device_condition_flags = stat_reg;
  assign o_command_error_flags = err_reg;
  assign o_sector_count = sc_reg;
  assign o_intrq = intrq_reg;
  assign o_lba_mode = lba_reg;
  assign o_max_option = opt_reg;
  assign o_set_max_go = setmax_reg;
  assign o_read_values = rv_reg;
  assign o_read_thresh = rt_reg;
  assign o_save_now = sv_reg;
  assign o_autosave_en = as_reg;
  assign o_offline_start = off_reg;
  assign o_apm_en = apm_reg;
  assign o_puis_en = puis_reg;
  assign o_spin_up = spin_reg;
  assign o_lookahead_en = rla_reg;
  assign o_revert_en = rev_reg;
  assign o_ext_start = ext_reg;
endmodule

// >>> ata_cmd_pkg.sv
// Purpose: Shared constants for the command decoder of a serial-link disk.
// Assumes: One 250 MHz clock and an asynchronous active-high reset.
// Notes: Task-file registers are plain ports; no bus is added.
package ata_cmd_pkg;
  localparam logic [7:0] CMD_MONITOR = 8'hB0;
  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0] CMD_POWER_QUERY = 8'hE5;
  localparam logic [7:0] CMD_POWER_QUERY_ALT = 8'h98;
  localparam logic [7:0] CMD_SET_MAX = 8'hF9;
  localparam logic [7:0] CMD_SET_MAX_EXT = 8'h37;
  localparam logic [7:0] CMD_READ_SECT = 8'h20;
  localparam logic [7:0] CMD_READ_VERIFY = 8'h40;
  localparam logic [7:0] FT_READ_VALUES = 8'hD0;
  localparam logic [7:0] FT_READ_THRESH = 8'hD1;
  localparam logic [7:0] FT_AUTOSAVE = 8'hD2;
  localparam logic [7:0] FT_SAVE_NOW = 8'hD3;
  localparam logic [7:0] FT_OFFLINE = 8'hD4;
  localparam logic [7:0] FT_APM_ON = 8'h05;
  localparam logic [7:0] FT_APM_OFF = 8'h85;
  localparam logic [7:0] FT_PUIS_ON = 8'h06;
  localparam logic [7:0] FT_PUIS_OFF = 8'h86;
  localparam logic [7:0] FT_SPIN_UP = 8'h07;
  localparam logic [7:0] FT_RLA_OFF = 8'h55;
  localparam logic [7:0] FT_RLA_ON = 8'hAA;
  localparam logic [7:0] FT_REVERT_OFF = 8'h66;
  localparam logic [7:0] FT_REVERT_ON = 8'hCC;
  localparam logic [7:0] FT_AUTOSAVE_ON = 8'hF1;
  localparam logic [7:0] PWR_CODE_STOPPED = 8'h00;
  localparam logic [7:0] PWR_CODE_ACTIVE = 8'hFF;
  localparam int RETRY_BIT = 0;
  localparam int DEV_SEL_BIT = 4;
  localparam int LBA_BIT = 6;
  localparam int OPTION_BIT = 0;
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK_DONE = 4;
  localparam int ST_DATA_REQ = 3;
  localparam int ST_CORRECTED = 2;
  localparam int ST_ERR = 0;
  localparam int ER_ABORT = 2;
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET = 8'h00;
  localparam logic [5:0] EXEC_CYCLES = 6'h04;
  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'h0,
    PWR_IDLE = 2'h1,
    PWR_STANDBY = 2'h3,
    PWR_SLEEP = 2'h2
  } pwr_state_t;
  typedef enum logic [1:0] {
    S_IDLE = 2'h0,
    S_EXEC = 2'h1,
    S_POST = 2'h3
  } cmd_state_t;
  typedef enum logic [4:0] {
    OP_NONE, OP_READ_VALUES, OP_READ_THRESH, OP_AUTOSAVE, OP_SAVE_NOW,
    OP_OFFLINE, OP_APM_ON, OP_APM_OFF, OP_PUIS_ON, OP_PUIS_OFF,
    OP_SPIN_UP, OP_RLA_OFF, OP_RLA_ON, OP_REVERT_OFF, OP_REVERT_ON,
    OP_POWER_QUERY, OP_SET_MAX, OP_PASS, OP_ABORT
  } op_t;
  // Folds the obsolete retry bit so both encodings decode alike.
  function automatic logic [7:0] fold_retry(input logic [7:0] code);
    fold_retry = code;
    if (code[7:4] == 4'h2 || code[7:4] == 4'h4) begin
      fold_retry[RETRY_BIT] = 1'b0;
    end
  endfunction
endpackage

// >>> ata_sub_decode.sv
// Purpose: Maps a command and feature byte to one internal operation.
// Assumes: Inputs come from the same clock domain.
// Notes: Purely combinational.
`timescale 1ns/1ps
module ata_sub_decode
  import ata_cmd_pkg::*;
(
  input wire logic [7:0] i_cmd, // Command code.
  input wire logic [7:0] i_feature, // Feature byte.
  output op_t o_op // Decoded operation.
);
  logic [7:0] cmd_f;
  assign cmd_f = fold_retry(i_cmd);
  always_comb begin
    o_op = OP_PASS;
    case (cmd_f)
      CMD_MONITOR: begin
        case (i_feature)
          FT_READ_VALUES: o_op = OP_READ_VALUES;
          FT_READ_THRESH: o_op = OP_READ_THRESH;
          FT_AUTOSAVE: o_op = OP_AUTOSAVE;
          FT_SAVE_NOW: o_op = OP_SAVE_NOW;
          FT_OFFLINE: o_op = OP_OFFLINE;
          default: o_op = OP_ABORT;
        endcase
      end
      CMD_SET_FEATURES: begin
        case (i_feature)
          FT_APM_ON: o_op = OP_APM_ON;
          FT_APM_OFF: o_op = OP_APM_OFF;
          FT_PUIS_ON: o_op = OP_PUIS_ON;
          FT_PUIS_OFF: o_op = OP_PUIS_OFF;
          FT_SPIN_UP: o_op = OP_SPIN_UP;
          FT_RLA_OFF: o_op = OP_RLA_OFF;
          FT_RLA_ON: o_op = OP_RLA_ON;
          FT_REVERT_OFF: o_op = OP_REVERT_OFF;
          FT_REVERT_ON: o_op = OP_REVERT_ON;
          default: o_op = OP_ABORT;
        endcase
      end
      CMD_POWER_QUERY, CMD_POWER_QUERY_ALT: o_op = OP_POWER_QUERY;
      CMD_SET_MAX, CMD_SET_MAX_EXT: o_op = OP_SET_MAX;
      default: o_op = OP_PASS;
    endcase
  end
endmodule

// >>> ata_cmd_core_sva.sv
// Purpose: Timing and result checks on the command decoder ports.
// Assumes: One clock; asynchronous active-high reset.
// Notes: Bound to every instance of the core.
`timescale 1ns/1ps
module ata_cmd_core_sva
  import ata_cmd_pkg::*;
(
  input wire logic i_sys_clk, // Clock.
  input wire logic i_rst, // Reset.
  input wire logic i_cmd_wr, // Command write.
  input wire logic [7:0] i_cmd, // Command code.
  input wire logic [7:0] i_feature, // Feature byte.
  input wire logic [1:0] i_power_state, // Power state.
  input wire logic [7:0] o_device_condition_flags, // Status.
  input wire logic [7:0] o_command_error_flags, // Error.
  input wire logic [7:0] o_sector_count, // Returned count.
  input wire logic o_intrq, // Completion pulse.
  input wire logic o_apm_en, // Power management.
  input wire logic o_puis_en, // Standby power-up.
  input wire logic o_lookahead_en, // Look-ahead.
  input wire logic o_revert_en, // Default reverting.
  input wire logic o_autosave_en, // Autosave.
  input wire logic o_read_values // Values pulse.
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  wire busy = o_device_condition_flags[ST_BUSY];
  wire acc = i_cmd_wr && !busy && !o_intrq;
  wire pq = acc && (i_cmd == CMD_POWER_QUERY || i_cmd == CMD_POWER_QUERY_ALT);
  wire own = i_cmd == CMD_MONITOR || i_cmd == CMD_SET_FEATURES;
  wire acc_own = acc && own || pq;
  wire [4:0] ens = {o_apm_en, o_puis_en, o_lookahead_en, o_revert_en,
    o_autosave_en};
  property p_busy_hold;
    acc_own |=> busy [*5] ##1 !busy;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy");
  property p_intrq_time;
    acc_own |-> ##6 o_intrq;
  endproperty
  a_intrq_time: assert property (p_intrq_time) else $error("late irq");
  property p_intrq_pulse;
    o_intrq |=> !o_intrq;
  endproperty
  a_intrq_pulse: assert property (p_intrq_pulse) else $error("wide");
  property p_pq_zero;
    pq && i_power_state[1] |-> ##6 o_sector_count == PWR_CODE_STOPPED;
  endproperty
  a_pq_zero: assert property (p_pq_zero) else $error("count not 00");
  property p_pq_ones;
    pq && !i_power_state[1] |-> ##6 o_sector_count == PWR_CODE_ACTIVE;
  endproperty
  a_pq_ones: assert property (p_pq_ones) else $error("count not FF");
  property p_pq_keep;
    pq |=> $stable(ens) [*6];
  endproperty
  a_pq_keep: assert property (p_pq_keep) else $error("query changed");
  property p_done_flags;
    o_intrq |-> o_device_condition_flags[7:5] == 3'h2 &&
      !o_device_condition_flags[ST_CORRECTED];
  endproperty
  a_done_flags: assert property (p_done_flags) else $error("flags");
  property p_abort_pair;
    o_intrq |-> o_device_condition_flags[ST_ERR] ==
      o_command_error_flags[ER_ABORT];
  endproperty
  a_abort_pair: assert property (p_abort_pair) else $error("abort");
  property p_apm_on;
    acc && i_cmd == CMD_SET_FEATURES && i_feature == FT_APM_ON
      |-> ##2 o_apm_en;
  endproperty
  a_apm_on: assert property (p_apm_on) else $error("apm not set");
  property p_values;
    acc && i_cmd == CMD_MONITOR && i_feature == FT_READ_VALUES
      |-> ##2 o_read_values ##1 !o_read_values;
  endproperty
  a_values: assert property (p_values) else $error("values pulse");
  cover property (acc_own);
  cover property (o_intrq && o_device_condition_flags[ST_ERR]);
  cover property (pq && i_power_state[1]);
endmodule

bind ata_cmd_core ata_cmd_core_sva i_sva (.i_sys_clk(i_sys_clk),
  .i_rst(i_rst), .i_cmd_wr(i_cmd_wr), .i_cmd(i_cmd),
  .i_feature(i_feature), .i_power_state(i_power_state),
  .o_device_condition_flags(o_device_condition_flags),
  .o_command_error_flags(o_command_error_flags),
  .o_sector_count(o_sector_count), .o_intrq(o_intrq),
  .o_apm_en(o_apm_en), .o_puis_en(o_puis_en),
  .o_lookahead_en(o_lookahead_en), .o_revert_en(o_revert_en),
  .o_autosave_en(o_autosave_en), .o_read_values(o_read_values));

// >>> ata_host_model.sv
// Purpose: Host model that writes the task file.
// Assumes: Signals change on the falling clock edge.
// Notes: Released bytes show the inverse of their last value.
`timescale 1ns/1ps
module ata_host_model (
  input wire logic i_sys_clk, // Device clock.
  input wire logic i_ext_start, // Command passed on.
  output logic o_cmd_wr = 1'b0, // Command write pulse.
  output logic [7:0] o_cmd = 8'h00, // Command code.
  output logic [7:0] o_feature = 8'h00, // Feature byte.
  output logic [7:0] o_count = 8'h00, // Sector count.
  output logic [7:0] o_dev_head = 8'h00, // Device/head.
  output logic o_ext_done = 1'b0 // Passed-on body done.
);
  // The passed-on body finishes on the falling edge after it starts, half a cycle later.
  always @(negedge i_sys_clk) begin
    o_ext_done <= i_ext_start;
  end
  task automatic issue(input logic [7:0] c, f, n, d);
    @(negedge i_sys_clk);
    o_cmd <= c;
    o_feature <= f;
    o_count <= n;
    o_dev_head <= d;
    o_cmd_wr <= 1'b1;
    @(negedge i_sys_clk);
    o_cmd_wr <= 1'b0;
    o_cmd <= ~c;
    o_feature <= ~f;
    o_count <= ~n;
    o_dev_head <= ~d;
  endtask
endmodule

// >>> ata_subcommand_and_power_check_tb_top.sv
// Purpose: Self-checking bench for the command decoder.
// Assumes: Host model drives the task file.
// Notes: Expected values come from tables below and from inline constants.
`timescale 1ns/1ps
module ata_subcommand_and_power_check_tb_top;
  import ata_cmd_pkg::*;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] pwr = 2'h0;
  logic ext_fault = 1'b0;
  logic cmd_wr, ext_done, intrq, lba, mopt, smax, rv, rt, sv, asv, offl;
  logic apm, puis, spin, rla, rev, exts;
  logic [7:0] cmd, feat, cnt, dh, st, er, sc;
  logic [6:0] pulses = 7'h00;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  logic [7:0] ef_f [9] = '{8'h05, 8'h06, 8'h07, 8'h85, 8'h86, 8'h55, 8'hAA,
    8'h66, 8'hCC};
  logic [3:0] ef_e [9] = '{4'hB, 4'hF, 4'hF, 4'h7, 4'h3, 4'h1, 4'h3, 4'h2,
    4'h3};
  logic [7:0] b_f [6] = '{8'hD0, 8'hD1, 8'hD3, 8'hD4, 8'hD2, 8'hD2};
  logic [7:0] b_n [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hF1, 8'h00};
  logic [6:0] b_p [6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h00, 7'h00};
  logic [5:0] b_a = 6'h10;
  initial begin
    forever #2 i_sys_clk = ~i_sys_clk;
  end
  ata_host_model i_host (.i_sys_clk(i_sys_clk), .i_ext_start(exts),
    .o_cmd_wr(cmd_wr), .o_cmd(cmd), .o_feature(feat), .o_count(cnt),
    .o_dev_head(dh), .o_ext_done(ext_done));
  ata_cmd_core i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_cmd_wr(cmd_wr), .i_cmd(cmd), .i_feature(feat), .i_sector_count(cnt),
    .i_device_head(dh), .i_power_state(pwr), .i_ext_done(ext_done),
    .i_ext_fault(ext_fault), .o_device_condition_flags(st),
    .o_command_error_flags(er), .o_sector_count(sc), .o_intrq(intrq),
    .o_lba_mode(lba), .o_max_option(mopt), .o_set_max_go(smax),
    .o_read_values(rv), .o_read_thresh(rt), .o_save_now(sv),
    .o_autosave_en(asv), .o_offline_start(offl), .o_apm_en(apm),
    .o_puis_en(puis), .o_spin_up(spin), .o_lookahead_en(rla),
    .o_revert_en(rev), .o_ext_start(exts));
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    pulses <= pulses | {rv, rt, sv, offl, spin, smax, exts};
    if (cyc == 5000) begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Issues one command and waits for its completion pulse.
  task automatic run(input logic [7:0] c, f, n, d, input int lat);
    int k;
    pulses = 7'h00;
    i_host.issue(c, f, n, d);
    for (k = 1; k < 60; k++) begin
      @(posedge i_sys_clk);
      #1;
      if (intrq === 1'b1) break;
    end
    chk({7'h00, intrq}, 8'h01);
    // Seen just after its launch edge; the next edge samples it.
    if (lat > 0) chk(8'(k + 1), 8'(lat));
    // The cycle of the pulse refuses writes, so wait it out.
    @(negedge i_sys_clk);
  endtask
  initial begin
    repeat (4) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    chk(st, STATUS_RESET);
    chk(er, ERROR_RESET);
    chk({4'h0, apm, puis, rla, rev}, 8'h03);
    for (int i = 0; i < 9; i++) begin
      run(CMD_SET_FEATURES, ef_f[i], 8'h00, i[0] ? 8'hB0 : 8'hA0, 6);
      chk(st, STATUS_RESET);
      chk({4'h0, apm, puis, rla, rev}, {4'h0, ef_e[i]});
      chk({1'b0, pulses}, i == 2 ? 8'h04 : 8'h00);
      chk({7'h00, lba}, 8'h00);
    end
    for (int i = 0; i < 6; i++) begin
      run(CMD_MONITOR, b_f[i], b_n[i], 8'hE0, 6);
      chk({1'b0, pulses}, {1'b0, b_p[i]});
      chk({7'h00, asv}, {7'h00, b_a[i]});
      chk({7'h00, lba}, 8'h01);
    end
    for (int i = 0; i < 2; i++) begin
      run(i ? CMD_MONITOR : CMD_SET_FEATURES, i ? 8'hC0 : 8'h13, 8'h00,
        8'hA0, 6);
      chk(st, 8'h51);
      chk(er, 8'h04);
    end
    for (int i = 0; i < 8; i++) begin
      pwr = 2'(i);
      run(i[2] ? CMD_POWER_QUERY_ALT : CMD_POWER_QUERY, 8'h00, 8'h00,
        8'hA0, 6);
      chk(sc, pwr[1] ? PWR_CODE_STOPPED : PWR_CODE_ACTIVE);
      chk({4'h0, apm, puis, rla, rev}, 8'h03);
    end
    for (int i = 0; i < 2; i++) begin
      run(CMD_SET_MAX, 8'h00, 8'(i), 8'hE0, 6);
      chk({7'h00, mopt}, 8'(i));
      chk({1'b0, pulses}, 8'h02);
    end
    i_rst = 1'b1;
    @(negedge i_sys_clk);
    i_rst = 1'b0;
    chk({6'h00, lba, mopt}, 8'h00);
    chk(st, STATUS_RESET);
    for (int i = 0; i < 2; i++) begin
      run(8'h20 | 8'(i), 8'h00, 8'h01, 8'hE0, 2);
      chk({1'b0, pulses}, 8'h01);
      chk(st, STATUS_RESET);
    end
    ext_fault = 1'b1;
    run(CMD_READ_VERIFY | 8'h01, 8'h00, 8'h01, 8'hE0, 2);
    chk({1'b0, pulses}, 8'h01);
    chk(st, 8'h51);
    chk(er, 8'h04);
    ext_fault = 1'b0;
    print_verdict();
  end
endmodule
